// >>> verilog/bcs_pkg.sv
// Purpose: shared constants, types and helpers of the backlight config store
// Assumes: 8-bit config words, one per aligned 32-bit Wishbone word
// Notes:   byte address of a word is four times its index
package bcs_pkg;

    // bus geometry
    localparam int          BCS_ADR_MIN_W  = 10;          // index bits plus byte offset
    localparam int          BCS_IDX_LSB    = 2;           // word aligned index
    localparam int          BCS_IDX_W      = 8;           // index width

    // word indices
    localparam logic [7:0]  BCS_IDX_DIM_CTRL   = 8'hA1;   // combined dimming control
    localparam logic [7:0]  BCS_IDX_BOOST_MODE = 8'hA2;   // boost_mode_config
    localparam logic [7:0]  BCS_IDX_BOOST_TRIM = 8'hA3;   // boost_trim_config
    localparam logic [7:0]  BCS_IDX_OUT_DRV    = 8'hA4;   // output_driver_config
    localparam logic [7:0]  BCS_IDX_STATUS     = 8'hB0;   // decoded status, read only

    // field positions
    localparam int          BCS_DIM_COMBO_BIT  = 5;       // combined pwm and current dimming
    localparam int          BCS_A2_SLOPE_HI    = 0;       // upper slope trim bit
    localparam int          BCS_A2_IMAX_BIT    = 1;       // boost current limit select
    localparam int          BCS_A2_QUARTER_BIT = 4;       // quarter (1) or half (0) mode
    localparam int          BCS_A3_FREQ_LSB    = 0;       // dim frequency code, 5 bits
    localparam int          BCS_A3_PSPWM_BIT   = 5;       // phase shift dimming enable
    localparam int          BCS_A3_UNDERVOLTAGE_THRESHOLD_SEL_LSB    = 6;       // undervoltage select, 2 bits
    localparam int          BCS_A4_HR_LSB      = 0;       // headroom code, 3 bits
    localparam int          BCS_A4_SLOPE_LO    = 3;       // lower slope trim bit
    localparam int          BCS_A4_FAULT_BIT   = 4;       // led fault threshold select
    localparam int          BCS_A4_IRES_BIT    = 5;       // current resistor enable
    localparam int          BCS_A4_RES_LSB     = 6;       // pwm resolution, 2 bits

    // reset values
    localparam logic [7:0]  BCS_DIM_CTRL_RST   = 8'h00;
    localparam logic [7:0]  BCS_BOOST_MODE_RST = 8'h02;   // higher current limit
    localparam logic [7:0]  BCS_BOOST_TRIM_RST = 8'h00;
    localparam logic [7:0]  BCS_OUT_DRV_RST    = 8'h00;

    // decode steps, slope in units of 0.125 percent
    localparam logic [6:0]  BCS_STEP_QUARTER   = 7'h14;   // 2.5 percent
    localparam logic [6:0]  BCS_STEP_HALF      = 7'h0A;   // 1.25 percent
    localparam logic [9:0]  BCS_STEP_HR_MV     = 10'h07D; // 125 mV

    // bus slave states
    typedef enum logic [1:0] {
        BCS_BUS_IDLE = 2'b01,
        BCS_BUS_ACK  = 2'b10
    } bcs_bus_st_t;

    // current drop for a trim code in the chosen mode
    function automatic logic [6:0] bcs_slope_units(input logic [1:0] trim,
                                                   input logic       quarter);
        logic [6:0] step;
        step = quarter ? BCS_STEP_QUARTER : BCS_STEP_HALF;
        return ({5'h00, trim} + 7'h01) * step;
    endfunction

    // headroom above saturation in mV
    function automatic logic [9:0] bcs_headroom_mv(input logic [2:0] code);
        return ({7'h00, code} + 10'h001) * BCS_STEP_HR_MV;
    endfunction

endpackage

// >>> verilog/bcs_dec_if.sv
// Purpose: carries stored fields to the decoders and decoded values back
// Assumes: all signals in the clk_i domain of the top
// Notes:   purely combinational carrier
`timescale 1ns/1ps
interface bcs_dec_if;
    logic [1:0] trim;          // assembled slope trim
    logic       quarter;       // quarter mode select
    logic       combo_en;      // combined dimming enabled
    logic [2:0] hr_code;       // headroom code
    logic [6:0] slope_drop;    // decoded drop, 0.125 percent units
    logic       slope_active;  // trim in force
    logic [9:0] headroom_mv;   // decoded headroom

    modport cfg      (output trim, quarter, combo_en, hr_code,
                      input  slope_drop, slope_active, headroom_mv);
    modport slope    (input  trim, quarter, combo_en,
                      output slope_drop, slope_active);
    modport headroom (input  hr_code, output headroom_mv);
endinterface

// >>> verilog/bcs_slope_trim.sv
// Purpose: turns the slope trim into a constant current drop
// Assumes: inputs stable from registers
// Notes:   no state; the top registers the result
`timescale 1ns/1ps
module bcs_slope_trim (
    // decoder carrier
    bcs_dec_if.slope dec
);
    import bcs_pkg::*;

    // drop only applies with combined dimming on
    always_comb begin
        dec.slope_active = dec.combo_en;
        if (dec.combo_en) begin
            dec.slope_drop = bcs_slope_units(dec.trim, dec.quarter);
        end else begin
            dec.slope_drop = '0;
        end
    end
endmodule

// >>> verilog/bcs_headroom.sv
// Purpose: turns the driver headroom code into millivolts
// Assumes: code stable from a register
// Notes:   no state; the top registers the result
`timescale 1ns/1ps
module bcs_headroom (
    // decoder carrier
    bcs_dec_if.headroom dec
);
    import bcs_pkg::*;

    // eight steps of 125 mV
    always_comb begin
        dec.headroom_mv = bcs_headroom_mv(dec.hr_code);
    end
endmodule

// >>> verilog/bcs_top.sv
// Purpose: backlight configuration word bank behind a classic Wishbone slave
// Assumes: single clock, synchronous active high reset, bus on clk_i
// Notes:   8-bit config words in the low byte lane, upper bits read as zero; the status word fills bits 17:0
//
// Behaviour
// - bit 1 word A2 selects boost limit
// - trim assembled from A2 bit0, A4 bit3
// - trim lowers current in 2.5/1.25 percent steps
// - A3 bit 5 enables phase shift dimming
// - A3 bits 4:0 hold frequency code
// - A4 bits 2:0 give 125 mV headroom steps
// - quarter bit picks quarter or half column
// - trim acts only with combined dimming on
`timescale 1ns/1ps
module bcs_top #(
    parameter int ADR_W = 10                           // byte address width
) (
    // clock, reset, enable
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    // wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // boost and supply fields
    output logic                  boost_current_limit_sel_o,
    output logic [1:0]            undervoltage_threshold_sel_o,
    // dimming fields
    output logic                  phase_shift_dim_enable_o,
    output logic [4:0]            dim_frequency_code_o,
    output logic [1:0]            pwm_resolution_o,
    output logic                  pwm_current_enable_o,
    output logic                  quarter_mode_o,
    output logic [1:0]            slope_trim_o,
    output logic [6:0]            slope_drop_o,
    output logic                  slope_active_o,
    // led driver fields
    output logic                  current_resistor_enable_o,
    output logic                  led_fault_threshold_sel_o,
    output logic [2:0]            driver_headroom_code_o,
    output logic [9:0]            headroom_mv_o
);
    import bcs_pkg::*;

    // refuse address widths that cannot hold the index
    generate
        if (ADR_W < BCS_ADR_MIN_W) begin : g_adr_chk
            $error("bcs_top: ADR_W too small for the word index");
        end
    endgenerate

    // whole module state
    typedef struct packed {
        bcs_bus_st_t bus;          // slave phase
        logic        ack;          // acknowledge flop
        logic [31:0] rdata;        // read data flop
        logic [7:0]  dim_ctrl;     // combined dimming control word
        logic [7:0]  boost_mode;   // boost_mode_config
        logic [7:0]  boost_trim;   // boost_trim_config
        logic [7:0]  out_drv;      // output_driver_config
        logic [6:0]  slope_drop;   // registered decoded drop
        logic        slope_active; // registered trim in force
        logic [9:0]  headroom_mv;  // registered decoded headroom
    } bcs_top_state_t;

    localparam bcs_top_state_t ST_RST = '{
        bus:          BCS_BUS_IDLE,
        ack:          1'b0,
        rdata:        '0,
        dim_ctrl:     BCS_DIM_CTRL_RST,
        boost_mode:   BCS_BOOST_MODE_RST,
        boost_trim:   BCS_BOOST_TRIM_RST,
        out_drv:      BCS_OUT_DRV_RST,
        slope_drop:   '0,
        slope_active: 1'b0,
        headroom_mv:  '0
    };

    bcs_top_state_t st_reg;              // registered state
    bcs_top_state_t st_next;             // next state

    logic [BCS_IDX_W-1:0] idx;           // word index
    logic                 hi_ok;         // no bits above the index
    logic                 req;           // request present
    logic                 wr_en;         // write commits this edge
    logic [31:0]          rd_word;       // read mux result

    bcs_dec_if dec ();                   // decoder carrier

    // address split
    assign idx   = wb_adr_i[BCS_IDX_LSB +: BCS_IDX_W];
    assign hi_ok = (wb_adr_i >> BCS_ADR_MIN_W) == '0;
    assign req   = wb_cyc_i & wb_stb_i;
    // write lands on the edge where the master sees ack
    assign wr_en = ce_i & req & wb_we_i & wb_sel_i[0] & hi_ok & (st_reg.bus == BCS_BUS_ACK);

    // stored fields to the decoders
    assign dec.trim     = {st_reg.boost_mode[BCS_A2_SLOPE_HI],
                           st_reg.out_drv[BCS_A4_SLOPE_LO]};
    assign dec.quarter  = st_reg.boost_mode[BCS_A2_QUARTER_BIT];
    assign dec.combo_en = st_reg.dim_ctrl[BCS_DIM_COMBO_BIT];
    assign dec.hr_code  = st_reg.out_drv[BCS_A4_HR_LSB +: 3];

    // decoders
    bcs_slope_trim u_slope (
        .dec (dec)
    );

    bcs_headroom u_headroom (
        .dec (dec)
    );

    // read mux, unmapped words read zero
    always_comb begin
        rd_word = '0;
        if (hi_ok) begin
            case (idx)
                BCS_IDX_DIM_CTRL:   rd_word = {24'h00_0000, st_reg.dim_ctrl};
                BCS_IDX_BOOST_MODE: rd_word = {24'h00_0000, st_reg.boost_mode};
                BCS_IDX_BOOST_TRIM: rd_word = {24'h00_0000, st_reg.boost_trim};
                BCS_IDX_OUT_DRV:    rd_word = {24'h00_0000, st_reg.out_drv};
                BCS_IDX_STATUS:     rd_word = {14'h0000, st_reg.headroom_mv,
                                               st_reg.slope_active, st_reg.slope_drop};
                default:            rd_word = '0;
            endcase
        end
    end

    // next state: bus slave, register writes, decoded copies
    always_comb begin
        st_next     = st_reg;
        st_next.ack = 1'b0;
        case (st_reg.bus)
            BCS_BUS_IDLE: begin
                // take request, answer next cycle
                if (req) begin
                    st_next.bus   = BCS_BUS_ACK;
                    st_next.ack   = 1'b1;
                    st_next.rdata = rd_word;
                end
            end
            BCS_BUS_ACK: begin
                // ack drops, write commits now
                st_next.bus = BCS_BUS_IDLE;
                if (wr_en) begin
                    case (idx)
                        BCS_IDX_DIM_CTRL:   st_next.dim_ctrl   = wb_dat_i[7:0];
                        BCS_IDX_BOOST_MODE: st_next.boost_mode = wb_dat_i[7:0];
                        BCS_IDX_BOOST_TRIM: st_next.boost_trim = wb_dat_i[7:0];
                        BCS_IDX_OUT_DRV:    st_next.out_drv    = wb_dat_i[7:0];
                        default:            st_next.out_drv    = st_reg.out_drv;
                    endcase
                end
            end
            default: begin
                // illegal code back to idle
                st_next.bus = BCS_BUS_IDLE;
            end
        endcase
        // decoded values registered one cycle behind fields
        st_next.slope_drop   = dec.slope_drop;
        st_next.slope_active = dec.slope_active;
        st_next.headroom_mv  = dec.headroom_mv;
    end

    // state register, frozen while ce_i is low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= ST_RST;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flops
    assign wb_dat_o                     = st_reg.rdata;
    assign wb_ack_o                     = st_reg.ack;
    assign boost_current_limit_sel_o    = st_reg.boost_mode[BCS_A2_IMAX_BIT];
    assign quarter_mode_o               = st_reg.boost_mode[BCS_A2_QUARTER_BIT];
    assign undervoltage_threshold_sel_o = st_reg.boost_trim[BCS_A3_UNDERVOLTAGE_THRESHOLD_SEL_LSB +: 2];
    assign phase_shift_dim_enable_o     = st_reg.boost_trim[BCS_A3_PSPWM_BIT];
    assign dim_frequency_code_o         = st_reg.boost_trim[BCS_A3_FREQ_LSB +: 5];
    assign pwm_resolution_o             = st_reg.out_drv[BCS_A4_RES_LSB +: 2];
    assign current_resistor_enable_o    = st_reg.out_drv[BCS_A4_IRES_BIT];
    assign led_fault_threshold_sel_o    = st_reg.out_drv[BCS_A4_FAULT_BIT];
    assign driver_headroom_code_o       = st_reg.out_drv[BCS_A4_HR_LSB +: 3];
    assign pwm_current_enable_o         = st_reg.dim_ctrl[BCS_DIM_COMBO_BIT];
    assign slope_trim_o                 = {st_reg.boost_mode[BCS_A2_SLOPE_HI],
                                           st_reg.out_drv[BCS_A4_SLOPE_LO]};
    assign slope_drop_o                 = st_reg.slope_drop;
    assign slope_active_o               = st_reg.slope_active;
    assign headroom_mv_o                = st_reg.headroom_mv;

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_imax_write: assert property (
        wr_en && idx == BCS_IDX_BOOST_MODE
        |=> boost_current_limit_sel_o == $past(wb_dat_i[BCS_A2_IMAX_BIT]))
        else $error("boost limit select not taken from write");

    chk_trim_assembly: assert property (
        wr_en && idx == BCS_IDX_OUT_DRV
        |=> slope_trim_o == {$past(slope_trim_o[1]), $past(wb_dat_i[BCS_A4_SLOPE_LO])})
        else $error("slope trim not assembled from both words");

    chk_quarter_drop: assert property (
        ce_i && pwm_current_enable_o && quarter_mode_o
        |=> slope_drop_o == bcs_slope_units($past(slope_trim_o), 1'b1))
        else $error("quarter mode drop wrong");

    chk_pspwm_write: assert property (
        wr_en && idx == BCS_IDX_BOOST_TRIM
        |=> phase_shift_dim_enable_o == $past(wb_dat_i[BCS_A3_PSPWM_BIT]))
        else $error("phase shift enable not taken from write");

    chk_freq_hold: assert property (
        !(wr_en && idx == BCS_IDX_BOOST_TRIM)
        |=> $stable(dim_frequency_code_o))
        else $error("frequency code changed without a write");

    chk_headroom_mv: assert property (
        ce_i && !rst_i
        |=> headroom_mv_o == ({7'h00, $past(driver_headroom_code_o)} + 10'h001) * 10'h07D)
        else $error("headroom millivolts wrong");

    chk_half_drop: assert property (
        ce_i && pwm_current_enable_o && !quarter_mode_o
        |=> slope_drop_o == ({5'h00, $past(slope_trim_o)} + 7'h01) * 7'h0A)
        else $error("half mode drop wrong");

    chk_combo_off: assert property (
        ce_i && !pwm_current_enable_o
        |=> slope_drop_o == '0 && !slope_active_o)
        else $error("trim active with combined dimming off");

endmodule

// >>> verif/bcs_top_tb.sv
// Purpose: self-checking bench for the backlight config store over Wishbone
// Assumes: 50 MHz clock, synchronous active high reset, fixed random seed
// Notes:   a shadow copy of the four words predicts every field and decode
`timescale 1ns/1ps
module bcs_top_tb;
    import bcs_pkg::*;

    // clock, reset, enable
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        ce_i     = 1'b1;
    // bus master side
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [9:0]  wb_adr_i = 10'h000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    // field outputs
    logic        boost_current_limit_sel_o;
    logic [1:0]  undervoltage_threshold_sel_o;
    logic        phase_shift_dim_enable_o;
    logic [4:0]  dim_frequency_code_o;
    logic [1:0]  pwm_resolution_o;
    logic        pwm_current_enable_o;
    logic        quarter_mode_o;
    logic [1:0]  slope_trim_o;
    logic [6:0]  slope_drop_o;
    logic        slope_active_o;
    logic        current_resistor_enable_o;
    logic        led_fault_threshold_sel_o;
    logic [2:0]  driver_headroom_code_o;
    logic [9:0]  headroom_mv_o;
    // bookkeeping
    int          mismatches  = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    logic [7:0]  sh [0:3];        // shadow of words A1..A4
    logic [31:0] q;
    logic [7:0]  idx;

    bcs_top #(.ADR_W(10)) bcs_top_inst (.*);

    // 20 ns clock
    always #10 clk_i = ~clk_i;

    // hang guard, far above the roughly 1300 cycles needed
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    // counts, verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one comparison
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // expected drop in 0.125 percent units
    function automatic logic [31:0] exp_drop(input logic [1:0] t, input logic qm, input logic c);
        if (!c) begin
            return 32'h0000_0000;
        end
        return (32'(t) + 32'h0000_0001) * (qm ? 32'h0000_0014 : 32'h0000_000A);
    endfunction

    // expected headroom in mV
    function automatic logic [31:0] exp_hr(input logic [2:0] c);
        return (32'(c) + 32'h0000_0001) * 32'h0000_007D;
    endfunction

    // classic single cycle; request held until ack is seen at an edge
    task automatic bus(input logic we, input logic [7:0] ix, input logic [31:0] d,
                       input logic [3:0] sel, output logic [31:0] rq);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {ix, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        rq = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    // write, track shadow, let fields and decodes settle
    task automatic wr(input logic [7:0] ix, input logic [7:0] d, input logic [3:0] sel);
        logic [31:0] rq;
        bus(1'b1, ix, {24'($urandom), d}, sel, rq);
        if (sel[0] && ix >= BCS_IDX_DIM_CTRL && ix <= BCS_IDX_OUT_DRV) begin
            sh[ix - BCS_IDX_DIM_CTRL] = d;
        end
        repeat (2) @(negedge clk_i);
    endtask

    // read and compare
    task automatic rd(input logic [7:0] ix, input logic [31:0] exp, input string name);
        logic [31:0] rq;
        bus(1'b0, ix, 32'h0000_0000, 4'hF, rq);
        chk(name, rq, exp);
    endtask

    // every field output, readback and status word against the shadow
    task automatic check_all();
        logic [1:0] t;
        t = {sh[1][0], sh[3][3]};
        chk("limit", boost_current_limit_sel_o, sh[1][1]);
        chk("trim", slope_trim_o, t);
        chk("quarter", quarter_mode_o, sh[1][4]);
        chk("drop", slope_drop_o, exp_drop(t, sh[1][4], sh[0][5]));
        chk("active", slope_active_o, sh[0][5]);
        chk("combo", pwm_current_enable_o, sh[0][5]);
        chk("uv", undervoltage_threshold_sel_o, sh[2][7:6]);
        chk("phase", phase_shift_dim_enable_o, sh[2][5]);
        chk("freq", dim_frequency_code_o, sh[2][4:0]);
        chk("res", pwm_resolution_o, sh[3][7:6]);
        chk("ires", current_resistor_enable_o, sh[3][5]);
        chk("fault", led_fault_threshold_sel_o, sh[3][4]);
        chk("hrcode", driver_headroom_code_o, sh[3][2:0]);
        chk("hrmv", headroom_mv_o, exp_hr(sh[3][2:0]));
        for (int k = 0; k < 4; k++) begin
            rd(BCS_IDX_DIM_CTRL + 8'(k), {24'h00_0000, sh[k]}, "readback");
        end
        rd(BCS_IDX_STATUS, {14'h0000, 10'(exp_hr(sh[3][2:0])), sh[0][5],
           7'(exp_drop(t, sh[1][4], sh[0][5]))}, "status");
    endtask

    // main sequence
    initial begin
        q = $urandom(32'h0000_ce21);
        sh = '{8'h00, 8'h02, 8'h00, 8'h00};
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        check_all();
        $display("test reset values done");
        // every trim code, both columns, combined on and off, every headroom code
        for (int i = 0; i < 16; i++) begin
            wr(BCS_IDX_DIM_CTRL, {2'b00, i[3], 5'h00}, 4'h1);
            wr(BCS_IDX_BOOST_MODE, {3'b000, i[2], 2'b00, i[0], i[1]}, 4'h1);
            wr(BCS_IDX_OUT_DRV, {4'h0, i[0], i[2:0]}, 4'h1);
            check_all();
        end
        $display("test trim and headroom sweep done");
        // random words, lanes and targets, some with byte lane 0 off
        for (int i = 0; i < 40; i++) begin
            idx = BCS_IDX_DIM_CTRL + 8'($urandom_range(3));
            wr(idx, 8'($urandom), 4'($urandom));
            check_all();
        end
        $display("test random writes done");
        // refused places: status is read only, unmapped reads zero
        wr(BCS_IDX_STATUS, 8'hFF, 4'hF);
        wr(8'h10, 8'hFF, 4'hF);
        rd(8'h10, 32'h0000_0000, "unmapped");
        rd(8'hA5, 32'h0000_0000, "unmapped");
        check_all();
        $display("test refused accesses done");
        // clock enable low freezes the bus answer
        @(posedge clk_i);
        ce_i <= 1'b0;
        fork
            wr(BCS_IDX_BOOST_TRIM, 8'h5A, 4'h1);
            begin
                repeat (4) @(negedge clk_i);
                chk("frozen ack", wb_ack_o, 32'h0000_0000);
                @(posedge clk_i);
                ce_i <= 1'b1;
            end
        join
        check_all();
        $display("test clock enable done");
        // reset in mid run brings back every reset value
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        sh = '{8'h00, 8'h02, 8'h00, 8'h00};
        @(negedge clk_i);
        chk("hrmv reset", headroom_mv_o, 32'h0000_0000);
        @(negedge clk_i);
        check_all();
        $display("test mid-run reset done");
        finish_test();
    end
endmodule
